// >>> alarm_channel_filter.sv
// per-channel consecutive-failure filter with release hysteresis
`timescale 1ns/10ps
module alarm_channel_filter
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                reset_n_i,
    input  wire logic                clk_en_i,
    // conversion of this channel
    input  wire logic                sample_i,
    input  wire logic [DATA_W-1:0]   data_i,
    input  wire logic [DATA_W-1:0]   low_i,
    input  wire logic [DATA_W-1:0]   high_i,
    input  wire logic                force_i,
    // shared settings
    input  wire logic [LIMIT_W-1:0]  limit_i,
    input  wire logic [MARGIN_W-1:0] margin_i,
    // result
    output logic                     alarm_o
);

    // ------------------------------------------------------------
    // compare
    // ------------------------------------------------------------
    logic [LIMIT_W-1:0] fail_cnt_r;
    logic [LIMIT_W-1:0] fail_cnt_nxt;
    logic               alarm_r;
    logic               alarm_nxt;
    logic               out_of_range;
    logic               inside_margin;
    logic [DATA_W:0]    rel_high;
    logic [DATA_W:0]    rel_low;

    // either side counts as the same failure
    assign out_of_range  = (data_i < low_i) || (data_i > high_i) || force_i;
    // margin added to the data, not taken off the high limit, so a wide margin cannot wrap
    assign rel_high      = {1'b0, data_i} + {6'h00, margin_i};
    assign rel_low       = {1'b0, low_i} + {6'h00, margin_i};
    assign inside_margin = (rel_high < {1'b0, high_i}) && ({1'b0, data_i} > rel_low)
                           && !force_i;

    // ------------------------------------------------------------
    // filter state
    // ------------------------------------------------------------
    always_comb begin
        fail_cnt_nxt = fail_cnt_r;
        alarm_nxt    = alarm_r;
        if (sample_i) begin
            if (alarm_r) begin
                if (inside_margin) begin
                    alarm_nxt    = 1'b0;
                    fail_cnt_nxt = '0;
                end
            end else if (out_of_range) begin
                // limit of n needs n+1 failures in a row
                if (fail_cnt_r >= limit_i) begin
                    alarm_nxt    = 1'b1;
                    fail_cnt_nxt = '0;
                end else begin
                    fail_cnt_nxt = fail_cnt_r + 4'h1;
                end
            end else begin
                fail_cnt_nxt = '0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fail_cnt_r <= '0;
            alarm_r    <= 1'b0;
        end else if (clk_en_i) begin
            fail_cnt_r <= fail_cnt_nxt;
            alarm_r    <= alarm_nxt;
        end
    end

    assign alarm_o = alarm_r;

endmodule

// >>> alarm_host.sv
// host model polling the alarm status
`timescale 1ns/10ps
module alarm_host
    import alarm_pkg::*;
(
    // clock
    input  wire logic                 clk_i,
    // status access
    input  wire logic [NUM_ALARM-1:0] alarm_status_i,
    output logic                      status_read_o
);
    initial status_read_o = 1'b0;
    // called just after an edge; value taken before the clearing edge
    task automatic poll(output logic [NUM_ALARM-1:0] seen, output logic dac_ok);
        seen = alarm_status_i;
        dac_ok = !seen[AL_REF_FLT];
        status_read_o = 1'b1;
        @(posedge clk_i);
        #1 status_read_o = 1'b0;
        // idle edge so a following poll never re-raises the strobe in the same step
        @(posedge clk_i);
        #1;
    endtask
endmodule

// >>> alarm_logic.sv
// out-of-range alarm logic: filters, thermal and reference flags, output response
//
// Contract
// - alarm voltage made apart from dac; action picks dac, alarm voltage or hi-z
// - forcing alarm voltage or hi-z also flags the output-monitor alarm
// - action none or clear releases output-monitor alarm after its next measurement
// - thermal warning above 85 c and error above 130 c from comparators
// - thermal alarms reported, drive pin, maskable, and steer output response
// - reference fault flag set when reference is off by more than 5 percent
// - each adc channel has its own out-of-range detection and alarm bit
// - alarm only after one more than the configured count of consecutive failures
// - high and low failures both count toward the consecutive limit
// - release only inside thresholds narrowed by hysteresis 0 to 127
// - one failure limit and one hysteresis serve all channels
// - external inputs and temperature alarm below low or above high threshold
// - thresholds 0x000 and 0xfff disable those alarms, the default
// - threshold fields are top eight bits; high lsbs 0xf, low lsbs 0x0
// - fixed limits for reference, analog supply, digital supply, constant voltage
// - output-monitor limits are expected code minus and plus 0x040
// - expected code from top twelve dac bits with range-dependent formula
// - status latched, cleared on read, reasserts; mask only gates pin
// - actions 0 none 1 clear 2 alarm voltage 3 hi-z; highest wins
// - alarm voltage high if enabled polarity pin or polarity bit is one
`timescale 1ns/10ps
module alarm_logic
    import alarm_pkg::*;
(
    // clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     clk_en_i,
    // conversion results
    input  wire conversion_t              conversion_i,
    // shared filter settings
    input  wire logic [LIMIT_W-1:0]       consecutive_failure_limit_i,
    input  wire logic [MARGIN_W-1:0]      release_margin_i,
    // thresholds of the external inputs and temperature
    input  wire threshold_t               external_input_a_thr_i,
    input  wire threshold_t               external_input_b_thr_i,
    input  wire threshold_t               temperature_thr_i,
    // dac code for the output monitor
    input  wire logic [DAC_W-1:0]         dac_code_i,
    input  wire logic                     dac_range_i,
    // analog comparator pins
    input  wire logic                     thermal_warning_i,
    input  wire logic                     thermal_error_i,
    input  wire logic                     reference_out_of_window_i,
    // response configuration
    input  wire logic [2*NUM_ALARM-1:0]   fault_response_select_i,
    input  wire logic [NUM_ALARM-1:0]     alarm_mask_i,
    input  wire logic                     polarity_pin_i,
    input  wire logic                     input_b_function_select_i,
    input  wire logic                     fault_level_polarity_bit_i,
    // status access
    input  wire logic                     status_read_i,
    output logic [NUM_ALARM-1:0]          alarm_status_o,
    output logic                          reference_fault_flag_o,
    output logic                          alarm_n_o,
    // output stage control
    output output_ctrl_t                  output_ctrl_o
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_meta_r;
    logic [3:0] pin_sync_r;
    logic       warn_s;
    logic       err_s;
    logic       ref_s;
    logic       pol_s;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pin_meta_r <= 4'h0;
            pin_sync_r <= 4'h0;
        end else if (clk_en_i) begin
            pin_meta_r <= {polarity_pin_i, reference_out_of_window_i, thermal_error_i, thermal_warning_i};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign warn_s = pin_sync_r[0];
    assign err_s  = pin_sync_r[1];
    assign ref_s  = pin_sync_r[2];
    assign pol_s  = pin_sync_r[3];

    // ------------------------------------------------------------
    // output-monitor expected code
    // ------------------------------------------------------------
    logic [DATA_W-1:0] dac_top;
    logic [18:0]       scaled;
    logic [DATA_W:0]   expected;
    logic [DATA_W:0]   mon_low_wide;
    logic [DATA_W:0]   mon_high_wide;
    logic [DATA_W-1:0] mon_low;
    logic [DATA_W-1:0] mon_high;

    assign dac_top       = dac_code_i[DAC_W-1 -: DATA_W];
    assign scaled        = dac_top * (dac_range_i ? R1_GAIN : R0_GAIN);
    assign expected      = ({1'b0, scaled[18:GAIN_SHIFT]}
                            + (dac_range_i ? R1_OFFSET : R0_OFFSET)) >> 1;
    // clamp so a window near the rails stays inside the code range
    assign mon_low_wide  = (expected > MON_WINDOW) ? expected - MON_WINDOW : 13'h0000;
    assign mon_high_wide = expected + MON_WINDOW;
    assign mon_low       = mon_low_wide[DATA_W-1:0];
    assign mon_high      = mon_high_wide[DATA_W] ? CODE_MAX : mon_high_wide[DATA_W-1:0];

    // ------------------------------------------------------------
    // per-channel limits
    // ------------------------------------------------------------
    logic [DATA_W-1:0] low_lim  [NUM_CHAN];
    logic [DATA_W-1:0] high_lim [NUM_CHAN];

    assign low_lim[CH_EXT_A]    = {external_input_a_thr_i.low, LOW_LSBS};
    assign high_lim[CH_EXT_A]   = {external_input_a_thr_i.high, HIGH_LSBS};
    assign low_lim[CH_EXT_B]    = {external_input_b_thr_i.low, LOW_LSBS};
    assign high_lim[CH_EXT_B]   = {external_input_b_thr_i.high, HIGH_LSBS};
    assign low_lim[CH_TEMP]     = {temperature_thr_i.low, LOW_LSBS};
    assign high_lim[CH_TEMP]    = {temperature_thr_i.high, HIGH_LSBS};
    assign low_lim[CH_REF]      = REF_LOW;
    assign high_lim[CH_REF]     = REF_HIGH;
    assign low_lim[CH_ASUP]     = ASUP_LOW;
    assign high_lim[CH_ASUP]    = ASUP_HIGH;
    assign low_lim[CH_DSUP]     = DSUP_LOW;
    assign high_lim[CH_DSUP]    = DSUP_HIGH;
    assign low_lim[CH_CONST]    = CONST_LOW;
    assign high_lim[CH_CONST]   = CONST_HIGH;
    assign low_lim[CH_OUT_MON]  = mon_low;
    assign high_lim[CH_OUT_MON] = mon_high;

    // ------------------------------------------------------------
    // response selection
    // ------------------------------------------------------------
    logic [NUM_ALARM-1:0] cond;
    logic [NUM_CHAN-1:0]  adc_alarm;
    action_t              worst;
    output_ctrl_t         ctrl_r;
    output_ctrl_t         ctrl_nxt;
    logic                 mon_force;

    assign cond = {ref_s, err_s, warn_s, adc_alarm};

    always_comb begin
        worst = ACT_NONE;
        for (int i = 0; i < NUM_ALARM; i++) begin
            if (cond[i] && (fault_response_select_i[2*i +: 2] > worst)) begin
                worst = action_t'(fault_response_select_i[2*i +: 2]);
            end
        end
    end

    // output no longer follows the code while forced; the monitor must see that
    assign mon_force = (ctrl_r.active == ACT_ALMV) || (ctrl_r.active == ACT_HIZ);

    always_comb begin
        ctrl_nxt                    = '0;
        ctrl_nxt.active             = worst;
        ctrl_nxt.clear_code         = (worst == ACT_CLEAR);
        ctrl_nxt.use_alarm_voltage  = (worst == ACT_ALMV);
        ctrl_nxt.buffer_hiz         = (worst == ACT_HIZ);
        // pin only steers polarity while input b is not a measurement input
        ctrl_nxt.alarm_voltage_high = (!input_b_function_select_i && pol_s)
                                      || fault_level_polarity_bit_i;
    end

    // ------------------------------------------------------------
    // channel filters
    // ------------------------------------------------------------
    generate
        for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
            alarm_channel_filter u_filter (
                .clk_i     (clk_i),
                .reset_n_i (reset_n_i),
                .clk_en_i  (clk_en_i),
                .sample_i  (conversion_i.valid && (conversion_i.chan == CHAN_W'(c))),
                .data_i    (conversion_i.data),
                .low_i     (low_lim[c]),
                .high_i    (high_lim[c]),
                .force_i   ((c == CH_OUT_MON) && mon_force),
                .limit_i   (consecutive_failure_limit_i),
                .margin_i  (release_margin_i),
                .alarm_o   (adc_alarm[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // status, pin and output registers
    // ------------------------------------------------------------
    logic [NUM_ALARM-1:0] status_r;
    logic [NUM_ALARM-1:0] status_nxt;
    logic                 alarm_n_r;

    // a live condition beats the read clear
    assign status_nxt = (status_read_i ? STATUS_RESET : status_r) | cond;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_r  <= STATUS_RESET;
            alarm_n_r <= PIN_IDLE_N;
            ctrl_r    <= '0;
        end else if (clk_en_i) begin
            status_r  <= status_nxt;
            alarm_n_r <= ~|(status_nxt & ~alarm_mask_i);
            ctrl_r    <= ctrl_nxt;
        end
    end

    assign alarm_status_o         = status_r;
    assign reference_fault_flag_o = status_r[AL_REF_FLT];
    assign alarm_n_o              = alarm_n_r;
    assign output_ctrl_o          = ctrl_r;

endmodule

// >>> alarm_logic_monitor.sv
// port-level assertions for the alarm logic
`timescale 1ns/10ps
module alarm_logic_monitor
    import alarm_pkg::*;
(
    // clock and reset
    input wire logic                   clk_i,
    input wire logic                   reset_n_i,
    input wire logic                   clk_en_i,
    // stimulus
    input wire conversion_t            conversion_i,
    input wire logic [LIMIT_W-1:0]     consecutive_failure_limit_i,
    input wire logic                   thermal_warning_i,
    input wire logic                   thermal_error_i,
    input wire logic [2*NUM_ALARM-1:0] fault_response_select_i,
    input wire logic [NUM_ALARM-1:0]   alarm_mask_i,
    input wire logic                   polarity_pin_i,
    input wire logic                   input_b_function_select_i,
    input wire logic                   fault_level_polarity_bit_i,
    input wire logic                   status_read_i,
    // results
    input wire logic [NUM_ALARM-1:0]   alarm_status_o,
    input wire logic                   reference_fault_flag_o,
    input wire logic                   alarm_n_o,
    input wire output_ctrl_t           output_ctrl_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_flag; reference_fault_flag_o == alarm_status_o[AL_REF_FLT]; endproperty
    a_flag: assert property (p_flag) else $error("flag differs from status bit");
    property p_pin; $past(clk_en_i) |-> alarm_n_o == !(|(alarm_status_o & ~$past(alarm_mask_i))); endproperty
    a_pin: assert property (p_pin) else $error("alarm pin disagrees with unmasked status");
    property p_sticky; !status_read_i |=> ($past(alarm_status_o) & ~alarm_status_o) == '0; endproperty
    a_sticky: assert property (p_sticky) else $error("status bit fell without a read");
    property p_decode; output_ctrl_o.clear_code == (output_ctrl_o.active == ACT_CLEAR)
        && output_ctrl_o.buffer_hiz == (output_ctrl_o.active == ACT_HIZ); endproperty
    a_decode: assert property (p_decode) else $error("output controls disagree with action");
    property p_pol; (fault_level_polarity_bit_i[*4]) or ((!input_b_function_select_i && polarity_pin_i)[*4])
        |-> output_ctrl_o.alarm_voltage_high; endproperty
    a_pol: assert property (p_pol) else $error("alarm voltage not high");
    property p_warn; (thermal_warning_i && clk_en_i)[*3] |=> alarm_status_o[AL_WARN]; endproperty
    a_warn: assert property (p_warn) else $error("thermal warning not reported");
    property p_err; (thermal_error_i && clk_en_i)[*3] |=> alarm_status_o[AL_THERM_ERR]; endproperty
    a_err: assert property (p_err) else $error("thermal error not reported");
    property p_hiz; (thermal_error_i && clk_en_i && fault_response_select_i[2*AL_THERM_ERR+:2] == 2'b11)[*4]
        |=> output_ctrl_o.active == ACT_HIZ; endproperty
    a_hiz: assert property (p_hiz) else $error("hi-z response missing");
    property p_ref; conversion_i.valid && clk_en_i && consecutive_failure_limit_i == 4'h0
        && conversion_i.chan == CH_REF && (conversion_i.data < REF_LOW || conversion_i.data > REF_HIGH)
        |-> ##2 alarm_status_o[CH_REF]; endproperty
    a_ref: assert property (p_ref) else $error("reference channel alarm missing");
    property p_mon; conversion_i.valid && clk_en_i && consecutive_failure_limit_i == 4'h0
        && conversion_i.chan == CH_OUT_MON && output_ctrl_o.active[1] |-> ##2 alarm_status_o[CH_OUT_MON]; endproperty
    a_mon: assert property (p_mon) else $error("output monitor not flagged");
endmodule

bind alarm_logic alarm_logic_monitor u_alarm_logic_monitor (.*);

// >>> alarm_logic_test.sv
// self-checking bench for the alarm logic
`timescale 1ns/10ps
module alarm_logic_test;
    import alarm_pkg::*;
    logic                   clk_i = 1'b0;
    logic                   reset_n_i = 1'b0;
    conversion_t            conv = '0;
    logic [LIMIT_W-1:0]     limit = '0;
    logic [MARGIN_W-1:0]    margin = '0;
    threshold_t             thr = '{low: 8'h00, high: 8'hff};
    logic [2*NUM_ALARM-1:0] sel = '0;
    logic [NUM_ALARM-1:0]   mask = '0;
    logic [NUM_ALARM-1:0]   seen;
    logic                   rng = 1'b0, warn = 1'b0, err = 1'b0, refw = 1'b0;
    logic                   pin = 1'b0, bsel = 1'b0, pol = 1'b0;
    logic                   rd, flag, alarm_n, dac_ok;
    output_ctrl_t           ctrl;
    int                     n_mismatch = 0, compares = 0, e_code;
    logic [13:0]            seq_q[$];
    logic [23:0]            lh;
    logic                   en = 1'b1;
    logic [DAC_W-1:0]       dac = 16'h8000;
    wire logic [NUM_ALARM-1:0] seen_w;
    always #10 clk_i = ~clk_i;
    alarm_logic u_alarm_logic (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en), .conversion_i(conv),
        .consecutive_failure_limit_i(limit), .release_margin_i(margin), .external_input_a_thr_i(thr),
        .external_input_b_thr_i(thr), .temperature_thr_i(thr), .dac_code_i(dac), .dac_range_i(rng),
        .thermal_warning_i(warn), .thermal_error_i(err), .reference_out_of_window_i(refw),
        .fault_response_select_i(sel), .alarm_mask_i(mask), .polarity_pin_i(pin),
        .input_b_function_select_i(bsel), .fault_level_polarity_bit_i(pol), .status_read_i(rd),
        .alarm_status_o(seen_w), .reference_fault_flag_o(flag), .alarm_n_o(alarm_n), .output_ctrl_o(ctrl));
    alarm_host u_alarm_host (.clk_i(clk_i), .alarm_status_i(seen_w), .status_read_o(rd));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic convert(input logic [2:0] ch, input logic [11:0] d);
        conv = '{valid: 1'b1, chan: ch, data: d};
        step(1);
        conv.valid = 1'b0;
        step(1);
    endtask
    // entry: [13] convert first, [12] expected alarm bit, [11:0] data
    task automatic run(input int ch);
        foreach (seq_q[i]) begin
            if (seq_q[i][13]) convert(3'(ch), seq_q[i][11:0]);
            check("alarm pin", alarm_n, !seq_q[i][12]);
            u_alarm_host.poll(seen, dac_ok);
            check("status", seen, 16'(seq_q[i][12]) << ch);
        end
    endtask
    task automatic print_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        step(4);
        reset_n_i = 1'b1;
        seq_q = '{14'h2000, 14'h2fff};
        for (int ch = 0; ch < 3; ch++) run(ch);
        thr = '{low: 8'h10, high: 8'h20};
        margin = 7'h04;
        for (int ch = 0; ch < 3; ch++) begin
            seq_q = '{14'h220f, 14'h2100, 14'h3210, 14'h320c, 14'h320a, 14'h0, 14'h30ff, 14'h3104, 14'h3105, 14'h0};
            limit = 4'h0;
            run(ch);
            seq_q = '{14'h2210, 14'h20ff, 14'h2150, 14'h2210, 14'h20ff, 14'h3210, 14'h3150, 14'h0};
            limit = 4'h2;
            run(ch);
        end
        limit = 4'h0;
        margin = 7'h00;
        for (int ch = 3; ch < 7; ch++) begin
            lh = (ch == 3) ? {REF_LOW, REF_HIGH} : (ch == 4) ? {ASUP_LOW, ASUP_HIGH} :
                 (ch == 5) ? {DSUP_LOW, DSUP_HIGH} : {CONST_LOW, CONST_HIGH};
            seq_q = '{{2'b10, lh[23:12]}, {2'b10, lh[11:0]}, {2'b11, 12'(lh[11:0] + 1)},
                      {2'b11, 12'(lh[23:12] - 1)}, {2'b11, 12'(lh[23:12] + 1)}, 14'h0};
            run(ch);
        end
        for (int r = 0; r < 4; r++) begin
            rng = r[0];
            dac = r[1] ? 16'h3450 : 16'h8000;
            e_code = (int'(dac[15:4]) * (rng ? 82 : 113) / 128 + (rng ? 655 : 492)) / 2;
            seq_q = '{{2'b10, 12'(e_code)}, {2'b10, 12'(e_code + 64)}, {2'b11, 12'(e_code + 65)},
                      {2'b11, 12'(e_code - 65)}, {2'b11, 12'(e_code)}, 14'h0};
            run(7);
        end
        mask = 11'h100;
        warn = 1'b1;
        step(5);
        check("masked pin", alarm_n, 1'b1);
        check("masked status", seen_w[AL_WARN], 1'b1);
        err = 1'b1;
        refw = 1'b1;
        sel[17:16] = ACT_CLEAR;
        step(5);
        check("pin", alarm_n, 1'b0);
        check("ref flag", flag, 1'b1);
        for (int a = 0; a < 4; a++) begin
            sel[19:18] = 2'(a);
            step(5);
            check("action", ctrl.active, (a > 1) ? a : 1);
            check("alarm voltage", ctrl.use_alarm_voltage, a == 2);
            check("hi-z", ctrl.buffer_hiz, a == 3);
            check("clear code", ctrl.clear_code, a < 2);
        end
        convert(CH_OUT_MON, 12'(e_code));
        u_alarm_host.poll(seen, dac_ok);
        check("monitor flag", seen[CH_OUT_MON], 1'b1);
        check("dac ok", dac_ok, 1'b0);
        sel = '0;
        {warn, err, refw} = 3'b000;
        step(5);
        convert(CH_OUT_MON, 12'(e_code));
        u_alarm_host.poll(seen, dac_ok);
        u_alarm_host.poll(seen, dac_ok);
        check("released", seen, 16'h0);
        for (int p = 0; p < 4; p++) begin
            {pin, pol} = 2'(p);
            step(5);
            check("polarity", ctrl.alarm_voltage_high, p != 0);
        end
        {bsel, pin, pol} = 3'b110;
        step(5);
        check("pin unused", ctrl.alarm_voltage_high, 1'b0);
        en = 1'b0;
        convert(CH_EXT_A, 12'h300);
        en = 1'b1;
        u_alarm_host.poll(seen, dac_ok);
        check("frozen", seen, 16'h0);
        convert(CH_EXT_A, 12'h300);
        u_alarm_host.poll(seen, dac_ok);
        check("after freeze", seen, 16'h1);
        print_verdict();
    end
endmodule

// >>> alarm_pkg.sv
// shared constants and types for the out-of-range alarm logic
package alarm_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned DATA_W     = 12;
    localparam int unsigned THR_W      = 8;
    localparam int unsigned CHAN_W     = 3;
    localparam int unsigned NUM_CHAN   = 8;
    localparam int unsigned LIMIT_W    = 4;
    localparam int unsigned MARGIN_W   = 7;
    localparam int unsigned DAC_W      = 16;
    localparam int unsigned NUM_ALARM  = 11;

    // ------------------------------------------------------------
    // channel and alarm positions
    // ------------------------------------------------------------
    localparam logic [CHAN_W-1:0] CH_EXT_A   = 3'h0;
    localparam logic [CHAN_W-1:0] CH_EXT_B   = 3'h1;
    localparam logic [CHAN_W-1:0] CH_TEMP    = 3'h2;
    localparam logic [CHAN_W-1:0] CH_REF     = 3'h3;
    localparam logic [CHAN_W-1:0] CH_ASUP    = 3'h4;
    localparam logic [CHAN_W-1:0] CH_DSUP    = 3'h5;
    localparam logic [CHAN_W-1:0] CH_CONST   = 3'h6;
    localparam logic [CHAN_W-1:0] CH_OUT_MON = 3'h7;
    localparam int unsigned AL_WARN      = 8;
    localparam int unsigned AL_THERM_ERR = 9;
    localparam int unsigned AL_REF_FLT   = 10;

    // ------------------------------------------------------------
    // fixed limits of the self-diagnostic channels
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] REF_LOW    = 12'h6d0;
    localparam logic [DATA_W-1:0] REF_HIGH   = 12'h92f;
    localparam logic [DATA_W-1:0] ASUP_LOW   = 12'h310;
    localparam logic [DATA_W-1:0] ASUP_HIGH  = 12'hd3f;
    localparam logic [DATA_W-1:0] DSUP_LOW   = 12'h9c0;
    localparam logic [DATA_W-1:0] DSUP_HIGH  = 12'hd3f;
    localparam logic [DATA_W-1:0] CONST_LOW  = 12'h690;
    localparam logic [DATA_W-1:0] CONST_HIGH = 12'h8cf;
    localparam logic [3:0]        HIGH_LSBS  = 4'hf;
    localparam logic [3:0]        LOW_LSBS   = 4'h0;
    localparam logic [DATA_W-1:0] CODE_MAX   = 12'hfff;

    // ------------------------------------------------------------
    // output-monitor expected code
    // ------------------------------------------------------------
    localparam logic [6:0]        R0_GAIN    = 7'h71;
    localparam logic [DATA_W:0]   R0_OFFSET  = 13'h1ec;
    localparam logic [6:0]        R1_GAIN    = 7'h52;
    localparam logic [DATA_W:0]   R1_OFFSET  = 13'h28f;
    localparam int unsigned       GAIN_SHIFT = 7;
    localparam logic [DATA_W:0]   MON_WINDOW = 13'h040;

    // ------------------------------------------------------------
    // fault responses, low to high priority
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ACT_NONE   = 2'b00,
        ACT_CLEAR  = 2'b01,
        ACT_ALMV   = 2'b10,
        ACT_HIZ    = 2'b11
    } action_t;

    typedef struct packed {
        logic                valid;
        logic [CHAN_W-1:0]   chan;
        logic [DATA_W-1:0]   data;
    } conversion_t;

    typedef struct packed {
        logic [THR_W-1:0]    low;
        logic [THR_W-1:0]    high;
    } threshold_t;

    typedef struct packed {
        action_t             active;
        logic                clear_code;
        logic                use_alarm_voltage;
        logic                alarm_voltage_high;
        logic                buffer_hiz;
    } output_ctrl_t;

    localparam logic [NUM_ALARM-1:0] STATUS_RESET = 11'h000;
    localparam logic                 PIN_IDLE_N   = 1'b1;

endpackage
